//--- core/tpac_pkg.sv
// Package with page map, configuration fields and defaults of the page access control
package tpac_pkg;
   localparam int unsigned NUM_PAGES = 8;
   localparam int unsigned PAGE_W = 32;
   localparam logic [2:0] PG_SERIAL = 3'h0;
   localparam logic [2:0] PG_RDR_PW = 3'h1;
   localparam logic [2:0] PG_RSVD = 3'h2;
   localparam logic [2:0] PG_CFG = 3'h3;
   localparam logic [2:0] PG_USER0 = 3'h4;
   localparam logic [31:0] RDR_PW_RESET = 32'h4D494B52;
   localparam logic [23:0] TAG_PW_RESET = 24'hAA4854;
   localparam logic [7:0] CFG_RESET = 8'h06;
   localparam int unsigned CFG_LSB = 24;
   localparam int unsigned CFG_LOCK_PW = 7;
   localparam int unsigned CFG_LOCK_CFG = 6;
   localparam int unsigned CFG_LOCK_U45 = 5;
   localparam int unsigned CFG_LOCK_U67 = 4;
   localparam int unsigned CFG_CRYPTO = 3;
   localparam int unsigned CFG_PROTO_HI = 2;
   localparam int unsigned CFG_PROTO_LO = 1;
   localparam int unsigned CFG_BIPHASE = 0;
   localparam logic [1:0] PROTO_NATIVE = 2'h3;
   typedef enum logic [1:0] {
      TPAC_OP_LOGIN = 2'b00,
      TPAC_OP_READ = 2'b01,
      TPAC_OP_WRITE = 2'b10
   } tpac_op_t;
   typedef enum logic [1:0] {
      TPAC_ST_OK = 2'b00,
      TPAC_ST_NOAUTH = 2'b01,
      TPAC_ST_DENIED = 2'b10,
      TPAC_ST_BADPW = 2'b11
   } tpac_status_t;
endpackage

//--- core/tpac_link_if.sv
// Interface joining reader and transponder over the command link
`timescale 1ns/10ps
interface tpac_link_if;
   logic req;
   tpac_pkg::tpac_op_t op;
   logic [2:0] page;
   logic [31:0] wdata;
   logic ack;
   tpac_pkg::tpac_status_t status;
   logic [31:0] rdata;
   logic present;
   modport transponder (
      input req, op, page, wdata,
      output ack, status, rdata, present
   );
   modport reader (
      output req, op, page, wdata,
      input ack, status, rdata, present
   );
endinterface

//--- core/tpac_transponder.sv
// Transponder end: eight protected pages, login and configuration locks
`timescale 1ns/10ps
module tpac_transponder #(
   parameter logic [31:0] SERIAL = 32'h12345678, // Arbitrary serial value
   parameter int unsigned NUM_PAGES = tpac_pkg::NUM_PAGES,
   parameter int unsigned PAGE_W = tpac_pkg::PAGE_W
) (
   input wire logic core_clk,
   input wire logic nrst,
   tpac_link_if.transponder link,
   output logic logged_in_q,
   output logic crypto_mode_q,
   output logic biphase_q,
   output logic [1:0] protocol_q
);
   logic [PAGE_W-1:0] mem_q [1:NUM_PAGES-1];
   logic ack_q;
   tpac_pkg::tpac_status_t status_q;
   logic [31:0] rdata_q;
   logic [7:0] cfg;
   logic rd_ok;
   logic wr_ok;
   logic pw_match;
   logic [31:0] page_val;
   logic [31:0] wr_val;
   logic present_q;
   logic is_login;
   logic is_read;
   logic is_write;
   logic wr_fire;
   logic rd_pass;
   tpac_pkg::tpac_status_t ans_status;
   logic [31:0] ans_rdata;
   logic [31:0] tag_word;
   logic crypto_sel;
   logic biphase_sel;
   logic [1:0] proto_sel;

   // Page address is three bits, so the lock decode serves exactly this many pages
   if (NUM_PAGES != tpac_pkg::NUM_PAGES) begin : g_bad_pages
      $error("tpac_transponder serves only its fixed page count");
   end
   // The configuration byte must sit at the top of a page word
   if (PAGE_W != tpac_pkg::PAGE_W) begin : g_bad_width
      $error("tpac_transponder serves only its fixed page width");
   end

   // Only the password page and, in crypto mode, the reserved page hide, both only once the password lock bit is set
   function automatic logic rd_allowed(input logic [2:0] p, input logic [7:0] c);
      logic r;
      r = 1'b1;
      if (p == tpac_pkg::PG_RDR_PW && c[tpac_pkg::CFG_LOCK_PW]) begin
         r = 1'b0;
      end
      if (p == tpac_pkg::PG_RSVD && c[tpac_pkg::CFG_LOCK_PW] && c[tpac_pkg::CFG_CRYPTO]) begin
         r = 1'b0;
      end
      return r;
   endfunction

   // Reserved page shares the page 1 lock; the serial page never takes a write
   function automatic logic wr_allowed(input logic [2:0] p, input logic [7:0] c);
      logic w;
      case (p)
         3'h0: w = 1'b0;
         3'h1, 3'h2: w = !c[tpac_pkg::CFG_LOCK_PW];
         3'h3: w = !c[tpac_pkg::CFG_LOCK_CFG];
         3'h4, 3'h5: w = !c[tpac_pkg::CFG_LOCK_U45];
         3'h6, 3'h7: w = !c[tpac_pkg::CFG_LOCK_U67];
         default: w = 1'b0;
      endcase
      return w;
   endfunction

   // Answer code of one request; a login is judged before any page access
   function automatic tpac_pkg::tpac_status_t answer_code(input tpac_pkg::tpac_op_t o,
         input logic logged, input logic pw_ok, input logic acc_ok);
      tpac_pkg::tpac_status_t s;
      s = tpac_pkg::TPAC_ST_DENIED;
      case (o)
         tpac_pkg::TPAC_OP_LOGIN: begin
            if (pw_ok) begin
               s = tpac_pkg::TPAC_ST_OK;
            end else begin
               s = tpac_pkg::TPAC_ST_BADPW;
            end
         end
         tpac_pkg::TPAC_OP_READ, tpac_pkg::TPAC_OP_WRITE: begin
            if (!logged) begin
               s = tpac_pkg::TPAC_ST_NOAUTH;
            end else if (acc_ok) begin
               s = tpac_pkg::TPAC_ST_OK;
            end
         end
         default: s = tpac_pkg::TPAC_ST_DENIED;
      endcase
      return s;
   endfunction

   // Configuration byte rides in the top of page 3; every lock reads it live
   assign cfg = mem_q[tpac_pkg::PG_CFG][31:tpac_pkg::CFG_LSB];
   assign rd_ok = rd_allowed(link.page, cfg);
   assign wr_ok = wr_allowed(link.page, cfg);
   // Full word compare; a partial match never logs in
   assign pw_match = link.wdata == mem_q[tpac_pkg::PG_RDR_PW];
   assign page_val = (link.page == tpac_pkg::PG_SERIAL) ? SERIAL : mem_q[link.page];
   // OTP bits can only go from 0 to 1
   assign wr_val = (link.page == tpac_pkg::PG_CFG) ?
      (link.wdata | {cfg[7:6], 30'h0}) : link.wdata;

   assign link.ack = ack_q;
   assign link.status = status_q;
   assign link.rdata = rdata_q;
   assign link.present = present_q;

   assign is_login = link.op == tpac_pkg::TPAC_OP_LOGIN;
   assign is_read = link.op == tpac_pkg::TPAC_OP_READ;
   assign is_write = link.op == tpac_pkg::TPAC_OP_WRITE;
   assign rd_pass = is_read && logged_in_q && rd_ok;
   // Refused writes never reach the page array
   assign wr_fire = link.req && is_write && logged_in_q && wr_ok;
   assign tag_word = {8'h00, mem_q[tpac_pkg::PG_CFG][23:0]};
   assign ans_status = answer_code(link.op, logged_in_q, pw_match, is_read ? rd_ok : wr_ok);
   // Refused reads answer zero so a locked page never leaks
   assign ans_rdata = (is_login && pw_match) ? tag_word : (rd_pass ? page_val : 32'h0);
   assign crypto_sel = cfg[tpac_pkg::CFG_CRYPTO];
   assign proto_sel = cfg[tpac_pkg::CFG_PROTO_HI:tpac_pkg::CFG_PROTO_LO];
   assign biphase_sel = cfg[tpac_pkg::CFG_BIPHASE];

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         // Page 0 has no storage: its word is the serial parameter
         for (int i = 1; i < NUM_PAGES; i++) begin
            mem_q[i] <= 32'h0;
         end
         mem_q[tpac_pkg::PG_RDR_PW] <= tpac_pkg::RDR_PW_RESET;
         mem_q[tpac_pkg::PG_CFG] <= {tpac_pkg::CFG_RESET, tpac_pkg::TAG_PW_RESET};
      end else if (wr_fire) begin
         mem_q[link.page] <= wr_val;
      end
   end

   // Every request is answered exactly one cycle later
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         present_q <= 1'b1;
      end else begin
         ack_q <= link.req;
         present_q <= 1'b1;
      end
   end

   // Status and data hold until the next request is answered
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         status_q <= tpac_pkg::TPAC_ST_OK;
         rdata_q <= 32'h0;
      end else if (link.req) begin
         status_q <= ans_status;
         rdata_q <= ans_rdata;
      end
   end

   // Any login attempt, good or bad, decides the session
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         logged_in_q <= 1'b0;
      end else if (link.req && is_login) begin
         logged_in_q <= pw_match;
      end
   end

   // Mode outputs trail the configuration byte by one cycle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         crypto_mode_q <= 1'b0;
         biphase_q <= 1'b0;
         protocol_q <= tpac_pkg::PROTO_NATIVE;
      end else begin
         crypto_mode_q <= crypto_sel;
         protocol_q <= proto_sel;
         biphase_q <= biphase_sel;
      end
   end
endmodule

//--- core/tpac_reader.sv
// Reader end: logs in, then issues single page reads and writes
`timescale 1ns/10ps
module tpac_reader (
   input wire logic core_clk,
   input wire logic nrst,
   tpac_link_if.reader link,
   input wire logic cmd_valid,
   input wire tpac_pkg::tpac_op_t cmd_op,
   input wire logic [2:0] cmd_page,
   input wire logic [31:0] cmd_wdata,
   input wire logic [31:0] cmd_password,
   output logic cmd_ready_q,
   output logic done_q,
   output logic fail_q,
   output logic [31:0] rdata_q,
   output logic [23:0] tag_pw_q
);
   typedef enum logic [1:0] {
      TPAC_R_IDLE = 2'b00,
      TPAC_R_LOGIN = 2'b01,
      TPAC_R_CFGRD = 2'b10,
      TPAC_R_ACCESS = 2'b11
   } tpac_rstate_t;
   tpac_rstate_t st_q;
   logic req_q;
   tpac_pkg::tpac_op_t op_q;
   tpac_pkg::tpac_op_t user_op_q;
   logic [2:0] page_q;
   logic [31:0] wdata_q;
   logic [7:0] cfg_q;
   logic cfg_bad;
   logic [31:0] merged;

   // Config writes go ahead only while the config byte read back shows native password mode with Manchester
   assign cfg_bad = link.rdata[31] == 1'b0 ? (link.rdata[27] | link.rdata[24] |
      (link.rdata[26:25] != tpac_pkg::PROTO_NATIVE)) :
      (link.rdata[27] | link.rdata[24] | (link.rdata[26:25] != tpac_pkg::PROTO_NATIVE));
   assign merged = (page_q == tpac_pkg::PG_CFG) ? {cfg_q, wdata_q[23:0]} : wdata_q;

   assign link.req = req_q;
   assign link.op = op_q;
   assign link.page = page_q;
   assign link.wdata = (op_q == tpac_pkg::TPAC_OP_WRITE) ? merged : wdata_q;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_q <= TPAC_R_IDLE;
         req_q <= 1'b0;
         op_q <= tpac_pkg::TPAC_OP_LOGIN;
         user_op_q <= tpac_pkg::TPAC_OP_READ;
         page_q <= 3'h0;
         wdata_q <= 32'h0;
         cfg_q <= 8'h00;
         cmd_ready_q <= 1'b1;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         rdata_q <= 32'h0;
         tag_pw_q <= 24'h000000;
      end else begin
         req_q <= 1'b0;
         done_q <= 1'b0;
         case (st_q)
            TPAC_R_IDLE: begin
               if (cmd_valid && link.present) begin
                  cmd_ready_q <= 1'b0;
                  fail_q <= 1'b0;
                  user_op_q <= cmd_op;
                  page_q <= cmd_page;
                  wdata_q <= cmd_password;
                  op_q <= tpac_pkg::TPAC_OP_LOGIN;
                  req_q <= 1'b1;
                  st_q <= TPAC_R_LOGIN;
               end
            end
            TPAC_R_LOGIN: begin
               if (link.ack) begin
                  tag_pw_q <= link.rdata[23:0];
                  if (link.status != tpac_pkg::TPAC_ST_OK ||
                        user_op_q == tpac_pkg::TPAC_OP_LOGIN) begin
                     fail_q <= link.status != tpac_pkg::TPAC_ST_OK;
                     done_q <= 1'b1;
                     cmd_ready_q <= 1'b1;
                     st_q <= TPAC_R_IDLE;
                  end else begin
                     op_q <= tpac_pkg::TPAC_OP_READ;
                     wdata_q <= cmd_wdata;
                     req_q <= 1'b1;
                     if (user_op_q == tpac_pkg::TPAC_OP_WRITE && page_q == tpac_pkg::PG_CFG) begin
                        page_q <= tpac_pkg::PG_CFG;
                        st_q <= TPAC_R_CFGRD;
                     end else begin
                        op_q <= user_op_q;
                        st_q <= TPAC_R_ACCESS;
                     end
                  end
               end
            end
            TPAC_R_CFGRD: begin
               if (link.ack) begin
                  cfg_q <= link.rdata[31:24];
                  fail_q <= link.status != tpac_pkg::TPAC_ST_OK || cfg_bad;
                  if (link.status == tpac_pkg::TPAC_ST_OK && !cfg_bad) begin
                     op_q <= tpac_pkg::TPAC_OP_WRITE;
                     req_q <= 1'b1;
                     st_q <= TPAC_R_ACCESS;
                  end else begin
                     done_q <= 1'b1;
                     cmd_ready_q <= 1'b1;
                     st_q <= TPAC_R_IDLE;
                  end
               end
            end
            TPAC_R_ACCESS: begin
               if (link.ack) begin
                  fail_q <= link.status != tpac_pkg::TPAC_ST_OK;
                  rdata_q <= link.rdata;
                  done_q <= 1'b1;
                  cmd_ready_q <= 1'b1;
                  st_q <= TPAC_R_IDLE;
               end
            end
            default: st_q <= TPAC_R_IDLE;
         endcase
      end
   end
endmodule

//--- bench/tpac_link_props.sv
// Concurrent checks on the command link between reader and transponder
`timescale 1ns/10ps
module tpac_link_props (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic req,
   input wire tpac_pkg::tpac_op_t op,
   input wire logic [2:0] page,
   input wire logic [31:0] wdata,
   input wire logic ack,
   input wire tpac_pkg::tpac_status_t status,
   input wire logic [31:0] rdata,
   input wire logic present
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   tpac_pkg::tpac_op_t op_q;
   logic [2:0] pg_q;
   logic [31:0] wd_q;
   logic [31:0] pw_q;
   logic [7:0] cfg_q;
   logic in_q;
   wire ok = status == tpac_pkg::TPAC_ST_OK;
   wire dn = status == tpac_pkg::TPAC_ST_DENIED;
   wire li = ack && op_q == tpac_pkg::TPAC_OP_LOGIN;
   wire wr = ack && op_q == tpac_pkg::TPAC_OP_WRITE && in_q;
   wire rd = ack && op_q == tpac_pkg::TPAC_OP_READ && in_q;
   always_ff @(posedge core_clk) begin
      if (req) begin
         op_q <= op;
         pg_q <= page;
         wd_q <= wdata;
      end
   end
   // Shadow of login state, password and config seen through answered requests
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         in_q <= 1'b0;
         pw_q <= tpac_pkg::RDR_PW_RESET;
         cfg_q <= tpac_pkg::CFG_RESET;
      end else begin
         if (li) in_q <= ok;
         if (wr && ok && pg_q == tpac_pkg::PG_RDR_PW) pw_q <= wd_q;
         if (wr && ok && pg_q == tpac_pkg::PG_CFG) cfg_q <= wd_q[31:24] | (cfg_q & 8'hC0);
      end
   end
   sequence s_answer;
      ##1 ack;
   endsequence
   sequence s_wr_to(lo, hi, lk);
      wr && pg_q >= lo && pg_q <= hi && lk;
   endsequence
   a_ack_latency: assert property (req |-> s_answer)
      else $error("request not answered after one cycle");
   a_no_stray: assert property (ack |-> $past(req))
      else $error("answer without request");
   a_login_check: assert property (li |-> ok == (wd_q == pw_q) &&
      (ok || status == tpac_pkg::TPAC_ST_BADPW))
      else $error("login result does not match stored password");
   a_need_login: assert property (ack && op_q != tpac_pkg::TPAC_OP_LOGIN && !in_q
      |-> status == tpac_pkg::TPAC_ST_NOAUTH)
      else $error("access answered without login");
   a_serial_ro: assert property (s_wr_to(0, 0, 1'b1) |-> dn)
      else $error("serial page write accepted");
   a_pw_locked: assert property (s_wr_to(1, 2, cfg_q[7]) |-> dn)
      else $error("locked password page write accepted");
   a_pw_hidden: assert property (rd && pg_q == 3'h1 && cfg_q[7] |-> dn && rdata == '0)
      else $error("locked password page readable");
   a_cfg_locked: assert property (s_wr_to(3, 3, cfg_q[6]) |-> dn)
      else $error("locked config page write accepted");
   a_u45_locked: assert property (s_wr_to(4, 5, cfg_q[5]) |-> dn)
      else $error("locked pages 4-5 write accepted");
   a_u67_locked: assert property (s_wr_to(6, 7, cfg_q[4]) |-> dn)
      else $error("locked pages 6-7 write accepted");
   a_cfg_otp: assert property (rd && ok && pg_q == 3'h3 |-> rdata[31:24] == cfg_q)
      else $error("config byte differs from written value");
   a_one_tag: assert property (present)
      else $error("transponder not present");
endmodule

//--- bench/tb.sv
// Self-checking bench: reader and transponder joined, plus a bench-driven transponder
`timescale 1ns/10ps
module tb;
   localparam logic [31:0] SER = 32'h0BADCAFE; // Arbitrary serial value
   localparam logic [31:0] P = tpac_pkg::RDR_PW_RESET;
   localparam tpac_pkg::tpac_op_t LI = tpac_pkg::TPAC_OP_LOGIN;
   localparam tpac_pkg::tpac_op_t RD = tpac_pkg::TPAC_OP_READ;
   localparam tpac_pkg::tpac_op_t WR = tpac_pkg::TPAC_OP_WRITE;
   localparam tpac_pkg::tpac_status_t OK = tpac_pkg::TPAC_ST_OK;
   localparam tpac_pkg::tpac_status_t NA = tpac_pkg::TPAC_ST_NOAUTH;
   localparam tpac_pkg::tpac_status_t DN = tpac_pkg::TPAC_ST_DENIED;
   localparam tpac_pkg::tpac_status_t BP = tpac_pkg::TPAC_ST_BADPW;
   typedef struct {tpac_pkg::tpac_op_t op; logic [2:0] pg; logic [31:0] wd, pw;
      logic fl; logic [31:0] rd;} tpac_row_t;
   tpac_row_t rows [15] = '{
      '{RD, 3'h0, 32'h0, P, 1'b0, SER},
      '{WR, 3'h0, 32'h0000FFFF, P, 1'b1, 32'h0},
      '{RD, 3'h0, 32'h0, P, 1'b0, SER},
      '{RD, 3'h1, 32'h0, P, 1'b0, P},
      '{RD, 3'h3, 32'h0, P, 1'b0, 32'h06AA4854},
      '{WR, 3'h4, 32'hC0FFEE01, P, 1'b0, 32'h0},
      '{RD, 3'h4, 32'h0, P, 1'b0, 32'hC0FFEE01},
      '{WR, 3'h7, 32'h7700AA55, P, 1'b0, 32'h0},
      '{RD, 3'h7, 32'h0, P, 1'b0, 32'h7700AA55},
      '{RD, 3'h4, 32'h0, 32'h0, 1'b1, 32'h0},
      '{WR, 3'h3, 32'hFF654321, P, 1'b0, 32'h0},
      '{RD, 3'h3, 32'h0, P, 1'b0, 32'h06654321},
      '{WR, 3'h1, 32'h12121212, P, 1'b0, 32'h0},
      '{RD, 3'h1, 32'h0, 32'h12121212, 1'b0, 32'h12121212},
      '{RD, 3'h1, 32'h0, P, 1'b1, 32'h0}};
   logic core_clk = 1'b0;
   logic nrst, cmd_valid, cmd_ready_q, done_q, fail_q, logged_in_q, crypto_mode_q, biphase_q;
   logic li_b, cr_b, bi_b;
   logic [1:0] protocol_q, pr_b;
   tpac_pkg::tpac_op_t cmd_op;
   logic [2:0] cmd_page;
   logic [31:0] cmd_wdata, cmd_password, rdata_q;
   logic [23:0] tag_pw_q;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   tpac_link_if link ();
   tpac_link_if link_b ();
   tpac_transponder #(.SERIAL(SER)) u_tpac_transponder (.core_clk(core_clk), .nrst(nrst),
      .link(link), .logged_in_q(logged_in_q), .crypto_mode_q(crypto_mode_q),
      .biphase_q(biphase_q), .protocol_q(protocol_q));
   tpac_transponder #(.SERIAL(SER)) u_tpac_transponder_b (.core_clk(core_clk), .nrst(nrst),
      .link(link_b), .logged_in_q(li_b), .crypto_mode_q(cr_b), .biphase_q(bi_b),
      .protocol_q(pr_b));
   tpac_reader u_tpac_reader (.core_clk(core_clk), .nrst(nrst), .link(link),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
      .cmd_password(cmd_password), .cmd_ready_q(cmd_ready_q), .done_q(done_q),
      .fail_q(fail_q), .rdata_q(rdata_q), .tag_pw_q(tag_pw_q));
   tpac_link_props u_tpac_link_props (.core_clk(core_clk), .nrst(nrst), .req(link.req),
      .op(link.op), .page(link.page), .wdata(link.wdata), .ack(link.ack),
      .status(link.status), .rdata(link.rdata), .present(link.present));
   always #5 core_clk = ~core_clk;
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic run(input tpac_row_t r);
      int n;
      n = 0;
      while (cmd_ready_q !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      cmd_op = r.op;
      cmd_page = r.pg;
      cmd_wdata = r.wd;
      cmd_password = r.pw;
      cmd_valid = 1'b1;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      while (done_q !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      chk(done_q, 1'b1, "done");
      chk(fail_q, r.fl, "fail");
      if (r.op == RD && !r.fl) chk(rdata_q, r.rd, "read data");
      @(negedge core_clk);
   endtask
   task automatic xb(input tpac_pkg::tpac_op_t o, input logic [2:0] p, input logic [31:0] d,
         input tpac_pkg::tpac_status_t s, input logic ce, input logic [31:0] e);
      link_b.op = o;
      link_b.page = p;
      link_b.wdata = d;
      link_b.req = 1'b1;
      @(negedge core_clk);
      link_b.req = 1'b0;
      link_b.wdata = ~d;
      chk(link_b.ack, 1'b1, "ack");
      chk(link_b.status, s, "status");
      if (ce) chk(link_b.rdata, e, "rdata");
      @(negedge core_clk);
   endtask
   initial begin
      nrst = 1'b0;
      {cmd_valid, cmd_page, cmd_wdata, cmd_password} = '0;
      cmd_op = LI;
      link_b.op = LI;
      {link_b.req, link_b.page, link_b.wdata} = '0;
      repeat (4) @(negedge core_clk);
      chk({logged_in_q, crypto_mode_q, biphase_q, protocol_q}, 5'h03, "mode");
      chk(cmd_ready_q, 1'b1, "ready");
      nrst = 1'b1;
      $display("reset test ended");
      foreach (rows[i]) run(rows[i]);
      run(tpac_row_t'{LI, 3'h0, 32'h0, 32'h12121212, 1'b0, 32'h0});
      chk(logged_in_q, 1'b1, "logged in");
      chk(tag_pw_q, 24'h654321, "tag password");
      $display("reader row test ended");
      xb(RD, 3'h4, 32'h0, NA, 1'b0, 32'h0);
      xb(LI, 3'h0, 32'h1, BP, 1'b0, 32'h0);
      chk(li_b, 1'b0, "logged out");
      xb(LI, 3'h0, P, OK, 1'b1, 32'h00AA4854);
      chk(li_b, 1'b1, "logged in");
      xb(WR, 3'h3, 32'h0B123456, OK, 1'b0, 32'h0);
      chk({cr_b, pr_b, bi_b}, 4'hB, "mode bits");
      xb(WR, 3'h3, 32'h86123456, OK, 1'b0, 32'h0);
      xb(WR, 3'h3, 32'h06123456, OK, 1'b0, 32'h0);
      xb(RD, 3'h3, 32'h0, OK, 1'b1, 32'h86123456);
      xb(WR, 3'h3, 32'hF6123456, OK, 1'b0, 32'h0);
      chk({cr_b, pr_b, bi_b}, 4'h6, "mode bits");
      xb(WR, 3'h1, 32'h1, DN, 1'b0, 32'h0);
      xb(RD, 3'h1, 32'h0, DN, 1'b1, 32'h0);
      xb(RD, 3'h2, 32'h0, OK, 1'b1, 32'h0);
      xb(WR, 3'h2, 32'h1, DN, 1'b0, 32'h0);
      xb(WR, 3'h4, 32'h1, DN, 1'b0, 32'h0);
      xb(WR, 3'h6, 32'h1, DN, 1'b0, 32'h0);
      xb(WR, 3'h0, 32'h1, DN, 1'b0, 32'h0);
      xb(WR, 3'h3, 32'h06000000, DN, 1'b0, 32'h0);
      xb(RD, 3'h3, 32'h0, OK, 1'b1, 32'hF6123456);
      $display("lock test ended");
      nrst = 1'b0;
      repeat (4) @(negedge core_clk);
      nrst = 1'b1;
      xb(LI, 3'h0, P, OK, 1'b0, 32'h0);
      xb(RD, 3'h3, 32'h0, OK, 1'b1, 32'h06AA4854);
      $display("second reset test ended");
      tally_and_finish();
   end
endmodule
